// ---- verilog/atm_phy_alarm_irq_and_control.sv ----
// receive-alarm status, masking, interrupt and control registers
//
// Contract
// [RULE1] status one: parities, cell delineation, signal, frame, optical loss
// [RULE2] status two/three: line/path alarms, counter overflows, rdi, ferf
// [RULE3] detector-backed alarm bits follow their external alarm level
// [RULE4] optical loss, path ais, path rdi bits follow internal condition
// [RULE5] any rise or fall of a level bit asserts the interrupt
// [RULE6] status read releases interrupt, level bits unchanged
// [RULE7] error bits latch until any status read, then stay clear
// [RULE8] interrupt is open-drain active low from receive status
// [RULE9] mask bit suppresses interrupt of matching status bit
// [RULE10] masks clear to zero on reset
// [RULE11] control registers clear on reset pin or id write
// [RULE12] control one bit0 disables single-bit header correction
// [RULE13] control one bit1 disables hec generation
// [RULE14] bit2 or terminal pin selects terminal loopback
// [RULE15] bit3 or facility pin selects facility loopback
// [RULE16] bit4 keeps cells with multi-bit header errors
// [RULE17] bit5 keeps idle cells, bit6 keeps unassigned cells
// [RULE18] bit7 stm-1 framing; control two clock loop and filler select
// [RULE19] idle and unassigned cells recognised by header only
// [RULE20] framing and clock loop bits ored with their pins
// [RULE21] filler cells carry 6a payload, header per filler select
// [RULE22] masking gates only the interrupt, status still records
// [RULE23] interrupt holds until status read, re-asserts on new event
module atm_phy_alarm_irq_and_control
	import phy_alarm_pkg::*;
#(
	parameter logic [3:0] ID_REVISION = 4'h1 // arbitrary revision value
)
(
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst_b,
	// controller interface, same clock
	input  wire logic [4:0]   host_addr,
	input  wire logic [7:0]   host_wdata,
	input  wire logic         host_wr,
	input  wire logic         host_rd,
	output logic      [7:0]   host_rdata,
	// detector alarms and error events, same clock
	input  wire alarm_level_t alarm_level,
	input  wire alarm_event_t alarm_event,
	// asynchronous pins
	input  wire logic         terminal_loopback_pin,
	input  wire logic         facility_loopback_pin,
	input  wire logic         sdh_frame_select_pin,
	input  wire logic         clock_loop_pin,
	// receive cell filter
	input  wire logic [39:0]  rx_header,
	input  wire logic         rx_header_multi_err,
	output logic              rx_cell_drop,
	// transmit filler cell
	output logic      [39:0]  filler_header,
	output logic      [7:0]   filler_payload,
	// control toward the datapath
	output control_out_t      control,
	// open-drain interrupt
	output logic              irq_out_n,
	output logic              irq_oe
);

	// ======================================================
	// elaboration check
	if (ID_REVISION == 4'hf)
		$error("ID_REVISION value f is reserved");

	// ======================================================
	// pin synchronisers
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
		end
		else
		begin
			pin_meta <= {clock_loop_pin, sdh_frame_select_pin,
			             facility_loopback_pin, terminal_loopback_pin};
			pin_sync <= pin_meta;
		end
	end

	// ======================================================
	// host decode
	wire soft_reset = host_wr && (host_addr == ADDR_ID); // RULE11
	wire status_read = host_rd && (host_addr == ADDR_STATUS_ONE ||
	                   host_addr == ADDR_STATUS_TWO ||
	                   host_addr == ADDR_STATUS_THREE);
	wire wr_control_one = host_wr && host_addr == ADDR_CONTROL_ONE;
	wire wr_control_two = host_wr && host_addr == ADDR_CONTROL_TWO;
	wire wr_mask_one    = host_wr && host_addr == ADDR_MASK_ONE;
	wire wr_mask_two    = host_wr && host_addr == ADDR_MASK_TWO;
	wire wr_mask_three  = host_wr && host_addr == ADDR_MASK_THREE;

	// ======================================================
	// control and mask registers
	logic [7:0] control_one;
	logic [7:0] control_two;
	logic [7:0] alarm_mask_one;
	logic [7:0] alarm_mask_two;
	logic [7:0] alarm_mask_three;

	function automatic logic [7:0] reg_next(input logic [7:0] cur,
		input logic wr, input logic [7:0] data, input logic [7:0] rst_val);
		if (soft_reset)
			return rst_val;
		return wr ? data : cur;
	endfunction : reg_next

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			control_one      <= RESET_CONTROL; // RULE11
			control_two      <= RESET_CONTROL; // RULE11
			alarm_mask_one   <= RESET_MASK; // RULE10
			alarm_mask_two   <= RESET_MASK; // RULE10
			alarm_mask_three <= RESET_MASK; // RULE10
		end
		else
		begin
			control_one <= reg_next(control_one, wr_control_one,
			                        host_wdata, RESET_CONTROL); // RULE11
			control_two <= reg_next(control_two, wr_control_two,
			                        host_wdata, RESET_CONTROL); // RULE11
			alarm_mask_one <= reg_next(alarm_mask_one, wr_mask_one,
			                           host_wdata, RESET_MASK); // RULE10
			alarm_mask_two <= reg_next(alarm_mask_two, wr_mask_two,
			                           host_wdata, RESET_MASK); // RULE10
			alarm_mask_three <= reg_next(alarm_mask_three, wr_mask_three,
			                             host_wdata & USED_BITS_THREE,
			                             RESET_MASK); // RULE10
		end
	end

	// ======================================================
	// status registers
	// new alarm levels and events, arranged as the status bytes
	wire [7:0] level_one = {alarm_level.ocarrier_loss,
		alarm_level.frame_loss_alarm, alarm_level.out_of_frame_alarm,
		alarm_level.signal_loss_alarm, alarm_level.cell_delineation_loss,
		3'h0}; // RULE1 RULE3 RULE4
	wire [7:0] level_two = {3'h0, alarm_level.path_ais,
		alarm_level.pointer_loss_alarm, alarm_level.rx_data_loss_alarm,
		alarm_level.line_far_end_fail_alarm,
		alarm_level.line_ais_alarm}; // RULE2 RULE3 RULE4
	wire [7:0] level_three = {3'h0, alarm_level.path_ferf,
		alarm_level.path_rdi, 3'h0}; // RULE2 RULE4
	wire [7:0] event_one   = {5'h00, alarm_event.parity_err}; // RULE1
	wire [7:0] event_two   = {alarm_event.block_ovf, 5'h00}; // RULE2
	wire [7:0] event_three = {5'h00, alarm_event.violation_ovf}; // RULE2

	logic [7:0] alarm_status_one;
	logic [7:0] alarm_status_two;
	logic [7:0] alarm_status_three;

	// level bits mirror, event bits latch; an event wins over a read
	function automatic logic [7:0] status_next(input logic [7:0] cur,
		input logic [7:0] lvl, input logic [7:0] evt,
		input logic [7:0] lvl_bits);
		logic [7:0] held;
		held = (status_read || soft_reset) ? 8'h00 : (cur & ~lvl_bits);
		return (lvl & lvl_bits) | held | (evt & ~lvl_bits);
	endfunction : status_next

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			alarm_status_one   <= RESET_STATUS;
			alarm_status_two   <= RESET_STATUS;
			alarm_status_three <= RESET_STATUS;
		end
		else
		begin
			alarm_status_one <= status_next(alarm_status_one, level_one,
				event_one, LEVEL_BITS_ONE); // RULE3 RULE7
			alarm_status_two <= status_next(alarm_status_two, level_two,
				event_two, LEVEL_BITS_TWO); // RULE3 RULE7
			alarm_status_three <= status_next(alarm_status_three,
				level_three, event_three, LEVEL_BITS_THREE); // RULE4 RULE7
		end
	end

	// ======================================================
	// interrupt
	// a level change or a fresh event on an unmasked bit triggers
	function automatic logic trig(input logic [7:0] cur,
		input logic [7:0] lvl, input logic [7:0] evt,
		input logic [7:0] lvl_bits, input logic [7:0] mask);
		logic [7:0] cause;
		cause = (((cur ^ lvl) & lvl_bits) | (evt & ~lvl_bits)) & ~mask;
		return |cause;
	endfunction : trig

	wire irq_trigger =
		trig(alarm_status_one, level_one, event_one,
		     LEVEL_BITS_ONE, alarm_mask_one) ||
		trig(alarm_status_two, level_two, event_two,
		     LEVEL_BITS_TWO, alarm_mask_two) ||
		trig(alarm_status_three, level_three, event_three,
		     LEVEL_BITS_THREE, alarm_mask_three); // RULE5 RULE9 RULE22

	logic irq_pending;
	// trigger wins over the releasing read so no event is lost
	wire next_irq_pending = irq_trigger ||
		(irq_pending && !status_read && !soft_reset); // RULE6 RULE23
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			irq_pending <= 1'b0;
		else
			irq_pending <= next_irq_pending;
	end

	assign irq_out_n = 1'b0; // RULE8
	assign irq_oe    = irq_pending; // RULE8

	// ======================================================
	// read data
	wire [7:0] id_value = {ID_FAMILY, ID_REVISION};
	logic [7:0] read_mux;
	always_comb
	begin
		case (host_addr)
			ADDR_STATUS_ONE:   read_mux = alarm_status_one;
			ADDR_STATUS_TWO:   read_mux = alarm_status_two;
			ADDR_STATUS_THREE: read_mux = alarm_status_three;
			ADDR_ID:           read_mux = id_value;
			ADDR_CONTROL_ONE:  read_mux = control_one;
			ADDR_CONTROL_TWO:  read_mux = control_two;
			ADDR_MASK_ONE:     read_mux = alarm_mask_one;
			ADDR_MASK_TWO:     read_mux = alarm_mask_two;
			ADDR_MASK_THREE:   read_mux = alarm_mask_three;
			default:           read_mux = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			host_rdata <= 8'h00;
		else if (host_rd)
			host_rdata <= read_mux;
	end

	// ======================================================
	// control outputs
	assign control.hdr_correct_en = !control_one[C1_NO_HDR_CORRECT]; // RULE12
	assign control.hec_gen_en     = !control_one[C1_NO_HEC_GEN]; // RULE13
	assign control.terminal_loopback =
		control_one[C1_TERM_LOOP] || pin_sync[0]; // RULE14
	assign control.facility_loopback =
		control_one[C1_FAC_LOOP] || pin_sync[1]; // RULE15
	assign control.keep_errored_cells = control_one[C1_KEEP_ERRORED]; // RULE16
	assign control.keep_idle_cells    = control_one[C1_KEEP_IDLE]; // RULE17
	assign control.keep_unassigned_cells =
		control_one[C1_KEEP_UNASSIGN]; // RULE17
	assign control.stm1_framing =
		control_one[C1_STM1_FRAME] || pin_sync[2]; // RULE18 RULE20
	assign control.clock_loop =
		control_two[C2_CLOCK_LOOP] || pin_sync[3]; // RULE18 RULE20
	assign control.filler_unassigned = control_two[C2_FILL_UNASSIGN]; // RULE18

	// ======================================================
	// receive cell drop decision, header only
	wire is_idle     = rx_header == IDLE_HEADER; // RULE19
	wire is_unassign = rx_header == UNASSIGN_HEADER; // RULE19
	assign rx_cell_drop =
		(is_idle && !control.keep_idle_cells) ||
		(is_unassign && !control.keep_unassigned_cells) ||
		(rx_header_multi_err && !control.keep_errored_cells); // RULE16 RULE17

	// ======================================================
	// filler cell content, registered
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			filler_header  <= IDLE_HEADER;
			filler_payload <= FILLER_PAYLOAD;
		end
		else
		begin
			filler_header  <= control.filler_unassigned ?
			                  UNASSIGN_HEADER : IDLE_HEADER; // RULE21
			filler_payload <= FILLER_PAYLOAD; // RULE21
		end
	end

	// ======================================================
	// assertions
	sequence s_status_read;
		host_rd && host_addr <= ADDR_STATUS_THREE;
	endsequence

	sequence s_released;
		##1 !irq_pending;
	endsequence

	a_level_mirror: assert property ( // RULE3
		@(posedge sys_clk) disable iff (!rst_b)
		1'b1 |=> alarm_status_two[0] == $past(alarm_level.line_ais_alarm))
		else $error("line ais status does not follow its alarm");

	a_carrier_follow: assert property ( // RULE4
		@(posedge sys_clk) disable iff (!rst_b)
		1'b1 |=> alarm_status_one[7] == $past(alarm_level.ocarrier_loss))
		else $error("optical loss status does not follow condition");

	a_fall_irq: assert property ( // RULE5
		@(posedge sys_clk) disable iff (!rst_b)
		$fell(alarm_status_one[6]) && !$past(alarm_mask_one[6])
		|-> irq_oe && !irq_out_n)
		else $error("falling level bit did not assert interrupt");

	a_read_release: assert property ( // RULE6
		@(posedge sys_clk) disable iff (!rst_b)
		s_status_read and !irq_trigger |-> s_released)
		else $error("status read did not release interrupt");

	a_level_kept: assert property ( // RULE6
		@(posedge sys_clk) disable iff (!rst_b)
		s_status_read and alarm_level.frame_loss_alarm
		|=> alarm_status_one[6])
		else $error("status read cleared a level bit");

	a_event_latch: assert property ( // RULE7
		@(posedge sys_clk) disable iff (!rst_b)
		alarm_event.parity_err[1] |=>
		alarm_status_one[1] [*2] ##0 1'b1 or
		(alarm_status_one[1] ##1 $past(status_read || soft_reset)))
		else $error("parity error bit not latched");

	a_event_clear: assert property ( // RULE7
		@(posedge sys_clk) disable iff (!rst_b)
		status_read && !alarm_event.block_ovf[0] |=> !alarm_status_two[5])
		else $error("overflow bit survived a status read");

	a_mask_gate: assert property ( // RULE9
		@(posedge sys_clk) disable iff (!rst_b)
		!irq_pending && alarm_mask_one == 8'hff && alarm_mask_two == 8'hff
		&& alarm_mask_three == USED_BITS_THREE |=> !irq_pending)
		else $error("interrupt asserted with every source masked");

	a_soft_reset: assert property ( // RULE11
		@(posedge sys_clk) disable iff (!rst_b)
		soft_reset |=> control_one == RESET_CONTROL &&
		control_two == RESET_CONTROL && alarm_mask_one == RESET_MASK)
		else $error("id write did not clear control and masks");

	a_irq_hold: assert property ( // RULE23
		@(posedge sys_clk) disable iff (!rst_b)
		irq_pending && !status_read && !soft_reset |=> irq_pending)
		else $error("interrupt dropped without a status read");

	a_loop_or: assert property ( // RULE14
		@(posedge sys_clk) disable iff (!rst_b)
		control_one[C1_TERM_LOOP] || ($past(rst_b, 2) &&
		$past(terminal_loopback_pin, 2)) |-> control.terminal_loopback)
		else $error("terminal loopback bit ignored");

endmodule : atm_phy_alarm_irq_and_control

// ---- pkg/phy_alarm_pkg.sv ----
// register map, field layouts and carriers for the receive-alarm block
package phy_alarm_pkg;

	// ======================================================
	// register offsets
	localparam logic [4:0] ADDR_STATUS_ONE  = 5'h00;
	localparam logic [4:0] ADDR_STATUS_TWO  = 5'h01;
	localparam logic [4:0] ADDR_STATUS_THREE = 5'h02;
	localparam logic [4:0] ADDR_ID          = 5'h03;
	localparam logic [4:0] ADDR_CONTROL_ONE = 5'h05;
	localparam logic [4:0] ADDR_CONTROL_TWO = 5'h06;
	localparam logic [4:0] ADDR_MASK_ONE    = 5'h07;
	localparam logic [4:0] ADDR_MASK_TWO    = 5'h08;
	localparam logic [4:0] ADDR_MASK_THREE  = 5'h09;

	// ======================================================
	// reset values
	localparam logic [7:0] RESET_MASK    = 8'h00;
	localparam logic [7:0] RESET_CONTROL = 8'h00;
	localparam logic [7:0] RESET_STATUS  = 8'h00;
	localparam logic [3:0] ID_FAMILY     = 4'ha;

	// ======================================================
	// which status bits mirror a level (1) or latch an event (0)
	localparam logic [7:0] LEVEL_BITS_ONE   = 8'hf8;
	localparam logic [7:0] LEVEL_BITS_TWO   = 8'h1f;
	localparam logic [7:0] LEVEL_BITS_THREE = 8'h18;
	localparam logic [7:0] USED_BITS_THREE  = 8'h1f;

	// ======================================================
	// control register one field positions
	localparam int C1_NO_HDR_CORRECT = 0;
	localparam int C1_NO_HEC_GEN     = 1;
	localparam int C1_TERM_LOOP      = 2;
	localparam int C1_FAC_LOOP       = 3;
	localparam int C1_KEEP_ERRORED   = 4;
	localparam int C1_KEEP_IDLE      = 5;
	localparam int C1_KEEP_UNASSIGN  = 6;
	localparam int C1_STM1_FRAME     = 7;
	// control register two field positions
	localparam int C2_CLOCK_LOOP     = 0;
	localparam int C2_FILL_UNASSIGN  = 1;

	// ======================================================
	// cell headers and filler payload
	localparam logic [39:0] IDLE_HEADER     = 40'h00_0000_0152;
	localparam logic [39:0] UNASSIGN_HEADER = 40'h00_0000_0055;
	localparam logic [7:0]  FILLER_PAYLOAD  = 8'h6a;

	// alarm levels from the detectors, bit order as the status registers
	typedef struct packed {
		logic ocarrier_loss;
		logic frame_loss_alarm;
		logic out_of_frame_alarm;
		logic signal_loss_alarm;
		logic cell_delineation_loss;
		logic path_ais;
		logic pointer_loss_alarm;
		logic rx_data_loss_alarm;
		logic line_far_end_fail_alarm;
		logic line_ais_alarm;
		logic path_ferf;
		logic path_rdi;
	} alarm_level_t;

	// one-cycle error events from parity checkers and counters
	typedef struct packed {
		logic [2:0] parity_err;     // b3, b2, b1
		logic [2:0] block_ovf;      // b3, b2, b1
		logic [2:0] violation_ovf;  // b3, b2, b1
	} alarm_event_t;

	// effective control levels toward the datapath
	typedef struct packed {
		logic hdr_correct_en;
		logic hec_gen_en;
		logic terminal_loopback;
		logic facility_loopback;
		logic keep_errored_cells;
		logic keep_idle_cells;
		logic keep_unassigned_cells;
		logic stm1_framing;
		logic clock_loop;
		logic filler_unassigned;
	} control_out_t;

endpackage : phy_alarm_pkg

// ---- verification/host_ctrl_model.sv ----
// host controller model: register cycles and the pulled-up interrupt line
module host_ctrl_model
	import phy_alarm_pkg::*;
(
	// clock
	input  wire logic       sys_clk,
	// register bus toward the device
	output logic      [4:0] host_addr,
	output logic      [7:0] host_wdata,
	output logic            host_wr,
	output logic            host_rd,
	input  wire logic [7:0] host_rdata,
	// open-drain interrupt
	input  wire logic       irq_out_n,
	input  wire logic       irq_oe,
	output logic            irq_line
);
	timeunit 1ns;
	timeprecision 1ns;

	// ======================================================
	// wire level: pulled up unless the device sinks it
	assign irq_line = irq_oe ? irq_out_n : 1'b1;

	initial
	begin
		host_addr  = 5'h1f;
		host_wdata = 8'h00;
		host_wr    = 1'b0;
		host_rd    = 1'b0;
	end

	// ======================================================
	// bus cycles; idle address is inverted, and after a write the data too, so that nothing
	// leans on a stale value, and one idle edge keeps strobes apart
	task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
		host_addr  = a;
		host_wdata = d;
		host_wr    = 1'b1;
		@(posedge sys_clk);
		#1;
		host_wr    = 1'b0;
		host_addr  = ~a;
		host_wdata = ~d;
		@(posedge sys_clk);
		#1;
	endtask : write_reg

	task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
		host_addr = a;
		host_rd   = 1'b1;
		@(posedge sys_clk);
		#1;
		d         = host_rdata;
		host_rd   = 1'b0;
		host_addr = ~a;
		@(posedge sys_clk);
		#1;
	endtask : read_reg

endmodule : host_ctrl_model

// ---- verification/atm_phy_alarm_irq_and_control_test.sv ----
// self-checking bench for the receive-alarm interrupt and control block
`define check(nm, exp, got) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) \
		begin \
			$display("BAD %s exp %h got %h", nm, exp, got); \
			failures++; \
		end \
	end

module atm_phy_alarm_irq_and_control_test
	import phy_alarm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ======================================================
	// constants and signals
	localparam logic [3:0]  REV    = 4'h3; // arbitrary revision value
	localparam logic [39:0] IDLE_H = 40'h00_0000_0152;
	localparam logic [39:0] UNAS_H = 40'h00_0000_0055;
	localparam logic [4:0]  LV_REG [12] = '{5'h02, 5'h02, 5'h01, 5'h01,
		5'h01, 5'h01, 5'h01, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
	localparam int LV_BIT [12] = '{3, 4, 0, 1, 2, 3, 4, 3, 4, 5, 6, 7};
	localparam int EV_BIT [9]  = '{0, 1, 2, 5, 6, 7, 0, 1, 2};
	logic         sys_clk;
	logic         rst_b;
	logic [4:0]   host_addr;
	logic [7:0]   host_wdata;
	logic         host_wr;
	logic         host_rd;
	logic [7:0]   host_rdata;
	alarm_level_t alarm_level;
	alarm_event_t alarm_event;
	logic [3:0]   pins;
	logic [39:0]  rx_header;
	logic         rx_header_multi_err;
	logic         rx_cell_drop;
	logic [39:0]  filler_header;
	logic [7:0]   filler_payload;
	control_out_t control;
	logic         irq_out_n;
	logic         irq_oe;
	logic         irq_line;
	logic [7:0]   rdv;
	int           failures = 0;
	int           samples_checked = 0;
	int           cycles = 0;

	atm_phy_alarm_irq_and_control #(.ID_REVISION(REV))
		atm_phy_alarm_irq_and_control_inst (
		.sys_clk(sys_clk), .rst_b(rst_b), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
		.host_rdata(host_rdata), .alarm_level(alarm_level),
		.alarm_event(alarm_event), .terminal_loopback_pin(pins[0]),
		.facility_loopback_pin(pins[1]), .sdh_frame_select_pin(pins[2]),
		.clock_loop_pin(pins[3]), .rx_header(rx_header),
		.rx_header_multi_err(rx_header_multi_err),
		.rx_cell_drop(rx_cell_drop), .filler_header(filler_header),
		.filler_payload(filler_payload), .control(control),
		.irq_out_n(irq_out_n), .irq_oe(irq_oe));

	host_ctrl_model host_ctrl_model_inst (
		.sys_clk(sys_clk), .host_addr(host_addr), .host_wdata(host_wdata),
		.host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
		.irq_out_n(irq_out_n), .irq_oe(irq_oe), .irq_line(irq_line));

	// ======================================================
	// clock, timeout and helpers
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// whole run needs about 450 cycles
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			failures++;
			conclude();
		end
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		host_ctrl_model_inst.write_reg(a, d);
	endtask : wr

	task automatic rd(input logic [4:0] a);
		host_ctrl_model_inst.read_reg(a, rdv);
	endtask : rd

	// pins: 0 terminal loop, 1 facility loop, 2 sdh framing, 3 clock loop
	function automatic control_out_t exp_ctl(logic [7:0] c1, logic [7:0] c2);
		return {~c1[0], ~c1[1], c1[2] | pins[0], c1[3] | pins[1], c1[4],
			c1[5], c1[6], c1[7] | pins[2], c2[0] | pins[3], c2[1]};
	endfunction : exp_ctl

	// ======================================================
	// scenarios
	task automatic t_reset;
		`check("irq_line", 1'b1, irq_line)
		`check("control", exp_ctl(8'h00, 8'h00), control)
		`check("filler", IDLE_H, filler_header)
		`check("payload", 8'h6a, filler_payload)
		for (int a = 0; a < 10; a++)
		begin
			rd(5'(a));
			`check("reg", (a == 3) ? {ID_FAMILY, REV} : 8'h00, rdv)
		end
	endtask : t_reset

	task automatic t_control;
		for (int b = 0; b < 10; b++)
		begin
			logic [15:0] v;
			v = 16'h0001 << b;
			wr(ADDR_CONTROL_ONE, v[7:0]);
			wr(ADDR_CONTROL_TWO, v[15:8]);
			rd(ADDR_CONTROL_ONE);
			`check("control_one", v[7:0], rdv)
			rd(ADDR_CONTROL_TWO);
			`check("control_two", v[15:8], rdv)
			`check("control", exp_ctl(v[7:0], v[15:8]), control)
			`check("filler", v[9] ? UNAS_H : IDLE_H, filler_header)
		end
		wr(ADDR_CONTROL_TWO, 8'h00);
		wr(ADDR_CONTROL_ONE, 8'h00);
		for (int p = 0; p < 5; p++)
		begin
			pins = 4'(5'h01 << p);
			step(3);
			`check("pin_ctl", exp_ctl(8'h00, 8'h00), control)
		end
	endtask : t_control

	task automatic t_drop;
		for (int k = 0; k < 24; k++)
		begin
			logic [7:0] c1;
			logic       e;
			c1 = (k < 6) ? 8'h00 : 8'(8'h08 << (k / 6));
			rx_header = (k % 3 == 0) ? IDLE_H :
				(k % 3 == 1) ? UNAS_H : 40'h12_3456_7800;
			rx_header_multi_err = ((k / 3) % 2) == 1;
			wr(ADDR_CONTROL_ONE, c1);
			e = (rx_header_multi_err & ~c1[4]) |
				((rx_header == IDLE_H) & ~c1[5]) |
				((rx_header == UNAS_H) & ~c1[6]);
			`check("drop", e, rx_cell_drop)
		end
	endtask : t_drop

	task automatic t_soft_reset;
		wr(ADDR_CONTROL_ONE, 8'hff);
		wr(ADDR_CONTROL_TWO, 8'h03);
		wr(ADDR_MASK_ONE, 8'h0f);
		wr(ADDR_STATUS_ONE, 8'hff);
		rd(ADDR_STATUS_ONE);
		`check("status_wr", 8'h00, rdv)
		wr(ADDR_ID, 8'h5a);
		rd(ADDR_CONTROL_ONE);
		`check("soft_c1", 8'h00, rdv)
		rd(ADDR_CONTROL_TWO);
		`check("soft_c2", 8'h00, rdv)
		rd(ADDR_MASK_ONE);
		`check("soft_mask", 8'h00, rdv)
	endtask : t_soft_reset

	task automatic t_levels;
		for (int i = 0; i < 12; i++)
		begin
			alarm_level = 12'h001 << i;
			step(2);
			`check("irq_rise", 1'b0, irq_line)
			rd(LV_REG[i]);
			`check("status", 8'h01 << LV_BIT[i], rdv)
			`check("irq_read", 1'b1, irq_line)
			rd(LV_REG[i]);
			`check("status_kept", 8'h01 << LV_BIT[i], rdv)
			alarm_level = '0;
			step(2);
			`check("irq_fall", 1'b0, irq_line)
			rd(LV_REG[i]);
			`check("status_clr", 8'h00, rdv)
		end
	endtask : t_levels

	task automatic t_events;
		for (int j = 0; j < 9; j++)
		begin
			alarm_event = 9'h001 << j;
			step(1);
			alarm_event = '0;
			step(1);
			`check("irq_event", 1'b0, irq_line)
			rd(5'(2 - j / 3));
			`check("event_set", 8'h01 << EV_BIT[j], rdv)
			alarm_event = 9'h001 << j;
			step(1);
			alarm_event = '0;
			rd((j < 6) ? 5'h00 : 5'h01);
			rd(5'(2 - j / 3));
			`check("event_clr", 8'h00, rdv)
		end
	endtask : t_events

	task automatic t_masks;
		wr(ADDR_MASK_ONE, 8'h02);
		alarm_event = 9'h080;
		step(1);
		alarm_event = '0;
		step(2);
		`check("irq_masked", 1'b1, irq_line)
		rd(ADDR_STATUS_ONE);
		`check("masked_status", 8'h02, rdv)
		wr(ADDR_MASK_ONE, 8'hff);
		alarm_level = 12'h100;
		step(2);
		`check("irq_masked_lvl", 1'b1, irq_line)
		rd(ADDR_STATUS_ONE);
		`check("masked_level", 8'h10, rdv)
		alarm_level = '0;
		wr(ADDR_MASK_THREE, 8'hff);
		rd(ADDR_MASK_THREE);
		`check("mask_three", 8'h1f, rdv)
		wr(ADDR_MASK_TWO, 8'hff);
		alarm_event = 9'h1ff;
		step(1);
		alarm_event = '0;
		step(1);
		`check("irq_all_masked", 1'b1, irq_line)
		rd(ADDR_STATUS_THREE);
		`check("all_masked_st", 8'h07, rdv)
		wr(ADDR_MASK_TWO, 8'h20);
		alarm_event = 9'h008;
		step(3);
		`check("irq_mask_two", 1'b1, irq_line)
		alarm_event = 9'h010;
		step(1);
		alarm_event = '0;
		step(6);
		`check("irq_held", 1'b0, irq_line)
		rd(ADDR_STATUS_TWO);
		`check("status_two", 8'h60, rdv)
		`check("irq_released", 1'b1, irq_line)
		alarm_event = 9'h010;
		step(1);
		alarm_event = '0;
		step(1);
		`check("irq_again", 1'b0, irq_line)
		rd(ADDR_STATUS_TWO);
	endtask : t_masks

	// ======================================================
	// main sequence
	initial
	begin
		rst_b = 1'b0;
		alarm_level = '0;
		alarm_event = '0;
		pins = 4'h0;
		rx_header = 40'h0;
		rx_header_multi_err = 1'b0;
		repeat (16) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		t_reset();
		t_control();
		t_drop();
		t_soft_reset();
		t_levels();
		t_events();
		t_masks();
		conclude();
	end

endmodule : atm_phy_alarm_irq_and_control_test
